// *** lspc_defs.svh ***
// constants of the loop setpoint and phase configuration block
`ifndef LSPC_DEFS_SVH
`define LSPC_DEFS_SVH
// ======================================================================
// command codes
`define LSPC_CMD_OPEN_LOOP   4'h0
`define LSPC_CMD_PHASE       4'h1
`define LSPC_CMD_SP_CODE     4'h2
`define LSPC_CMD_SP_TRIM     4'h3
`define LSPC_CMD_SP_OFFSET   4'h4
`define LSPC_CMD_MARGIN_UP   4'h5
`define LSPC_CMD_MARGIN_DOWN 4'h6
`define LSPC_CMD_CEILING     4'h7
`define LSPC_CMD_MARGIN_MODE 4'h8
`define LSPC_CMD_OL_PERIOD   4'h9
`define LSPC_CMD_CONTROL     4'ha
`define LSPC_CMD_STATUS      4'hb
// ======================================================================
// field positions
`define LSPC_OL_EN_BIT       0
`define LSPC_OL_NPH_MSB      4
`define LSPC_OL_NPH_LSB      1
`define LSPC_OL_ON_MSB       15
`define LSPC_OL_ON_LSB       5
`define LSPC_CTRL_CHK_BIT    0
`define LSPC_ST_CHK_BUSY     4
`define LSPC_ST_CHK_PASS     5
// ======================================================================
// reset values
`define LSPC_SP_CODE_RST     5'h06
`define LSPC_FIELD6_RST      6'h00
`define LSPC_PHASE_RST       5'h00
`define LSPC_OL_CFG_RST      16'h0000
`define LSPC_OL_PER_RST      16'h0064
// ======================================================================
// setpoint arithmetic
`define LSPC_CODE_OFS        14'h0009
`define LSPC_CODE_STEP       14'h0029
`define LSPC_CEIL_SHIFT      5
`define LSPC_REF_MAX         14'h07ff
`define LSPC_MAX_PHASES      4'h8
// ======================================================================
// timing
`define LSPC_CLK_NS          40
`define LSPC_FILT_NS         88000
`define LSPC_FILT_CYC        ((`LSPC_FILT_NS + `LSPC_CLK_NS - 1) / `LSPC_CLK_NS)
`define LSPC_BLANK_NS        920000
`define LSPC_BLANK_CYC       ((`LSPC_BLANK_NS + `LSPC_CLK_NS - 1) / `LSPC_CLK_NS)
`define LSPC_OL_COARSE_NS    25
`define LSPC_OL_FINE_DIV     64
`endif

// *** lspc_pkg.sv ***
// types of the loop setpoint and phase configuration block
package lspc_pkg;
   typedef enum logic [1:0] {MARGIN_OFF, MARGIN_UP, MARGIN_DOWN} lspc_margin_t;
   typedef enum logic {CHK_IDLE, CHK_RUN} lspc_chk_t;
   typedef struct packed {
      logic [4:0]   code;
      logic [5:0]   trim;
      logic [5:0]   offs;
      logic [5:0]   up;
      logic [5:0]   down;
      logic [5:0]   ceil;
      lspc_margin_t margin;
   } lspc_sp_cfg_t;
endpackage

// *** lspc_top.sv ***
// feedback-open monitor, open-loop bypass, phase split and setpoint logic
`timescale 1ns/1ps
`include "lspc_defs.svh"

// Overview of operation
// - sense comparator high past filter time after blanking sets flag and tristate
// - return comparator filtered the same way; blanking lasts 0.92 ms (23000 cycles)
// - flag stays until comparator clears and loop enable rises
// - self-check procedure exercises the feedback-open monitor
// - open-loop word: bit 0 enables, bits 4:1 give active phases
// - ON time is coarse 25 ns steps plus fine 25/64 ns steps
// - open-loop drives programmed PWMs at fixed period and ON time
// - at most 8 phases total, at most 4 on loop 2
// - outside open-loop, unassigned phases tristated with current monitor disabled
// - phase code decodes to loop 1 low phases and loop 2 high phases
// - reference is 50 mV times code plus 9; code 0 gives 0 V unless sum is at or over ceiling
// - signed trim plus offset, times fine step, added to reference unless margin up or down is selected
// - margin mode adds chosen unsigned margin times fine step to base
// - six-bit ceiling field guards reference, resets to zero
// - sum at or over ceiling clamps reference to 32*(ceiling+1)-1 steps
module lspc_top #(
   parameter int BLANK_CYC = `LSPC_BLANK_CYC
) (
   input  wire logic              REF_CLK_IN,
   input  wire logic              SYS_RST_IN,
   input  wire logic              CMD_WR_IN,
   input  wire logic [3:0]        CMD_CODE_IN,
   input  wire logic              CMD_PAGE_IN,
   input  wire logic [15:0]       CMD_WDATA_IN,
   output logic      [15:0]       CMD_RDATA_OUT,
   input  wire logic [1:0]        SENSE_POS_CMP_IN,
   input  wire logic [1:0]        SENSE_RTN_CMP_IN,
   input  wire logic [1:0]        LOOP_ENABLE_IN,
   input  wire logic [7:0]        PWM_LOOP_IN,
   output logic      [7:0]        PWM_OUT,
   output logic      [7:0]        PWM_OE_OUT,
   output logic      [7:0]        PHASE_CURRENT_SENSE_EN_OUT,
   output logic      [1:0]        SENSE_OPEN_OUT,
   output logic      [1:0]        RETURN_OPEN_OUT,
   output logic                   SAFE_TRISTATE_OUT,
   output logic      [1:0][10:0]  REF_CODE_OUT
);

   // ===================================================================
   // functions
   function automatic logic signed [7:0] lspc_sum(input lspc_pkg::lspc_sp_cfg_t c);
      lspc_sum = $signed({3'h0, c.code}) + $signed({{2{c.trim[5]}}, c.trim})
               + $signed({{2{c.offs[5]}}, c.offs});
   endfunction

   function automatic logic [10:0] lspc_ref(input lspc_pkg::lspc_sp_cfg_t c);
      logic [11:0]        clamp;
      logic signed [13:0] acc;
      clamp = ((12'(c.ceil) + 12'h001) << `LSPC_CEIL_SHIFT) - 12'h001;
      acc = $signed(({9'h000, c.code} + `LSPC_CODE_OFS) * `LSPC_CODE_STEP);
      if (c.margin == lspc_pkg::MARGIN_UP) begin
         acc = acc + $signed({8'h00, c.up});
      end else if (c.margin == lspc_pkg::MARGIN_DOWN) begin
         acc = acc + $signed({8'h00, c.down});
      end else begin
         acc = acc + $signed({{8{c.trim[5]}}, c.trim})
                   + $signed({{8{c.offs[5]}}, c.offs});
      end
      if (lspc_sum(c) >= $signed({2'h0, c.ceil})) begin
         lspc_ref = clamp[10:0];
      end else if (c.code == 5'h00) begin
         lspc_ref = 11'h000;
      end else if (acc < 0) begin
         lspc_ref = 11'h000;
      end else if (acc > $signed(`LSPC_REF_MAX)) begin
         lspc_ref = 11'h7ff;
      end else begin
         lspc_ref = acc[10:0];
      end
   endfunction

   function automatic logic [15:0] lspc_phase_mask(input logic [4:0] code);
      logic [4:0] n1;
      logic [7:0] l2;
      n1 = 5'h00;
      l2 = 8'h00;
      if (code >= 5'h01 && code <= 5'h08) begin
         n1 = code;
      end else if (code >= 5'h09 && code <= 5'h0f) begin
         n1 = code - 5'h08;
         l2 = 8'h80;
      end else if (code >= 5'h10 && code <= 5'h15) begin
         n1 = code - 5'h0f;
         l2 = 8'hc0;
      end else if (code >= 5'h16 && code <= 5'h1a) begin
         n1 = code - 5'h15;
         l2 = 8'he0;
      end else if (code >= 5'h1b && code <= 5'h1e) begin
         n1 = code - 5'h1a;
         l2 = 8'hf0;
      end
      lspc_phase_mask = {l2, 8'((9'h001 << n1) - 9'h001)};
   endfunction

   // ===================================================================
   // command registers
   logic [15:0]                ol_cfg_q, ol_cfg_d, ol_per_q, ol_per_d;
   logic [4:0]                 phase_cfg_q, phase_cfg_d;
   lspc_pkg::lspc_sp_cfg_t     sp_q [2];
   lspc_pkg::lspc_sp_cfg_t     sp_d [2];
   lspc_pkg::lspc_sp_cfg_t     sp_rst;
   lspc_pkg::lspc_chk_t        chk_q, chk_d;
   logic                       chk_pass_q, chk_pass_d;
   logic [3:0]                 hit, flag, comp, comp_eff;
   logic                       chk_run;

   assign sp_rst = '{code: `LSPC_SP_CODE_RST, trim: `LSPC_FIELD6_RST,
                     offs: `LSPC_FIELD6_RST, up: `LSPC_FIELD6_RST,
                     down: `LSPC_FIELD6_RST, ceil: `LSPC_FIELD6_RST,
                     margin: lspc_pkg::MARGIN_OFF};
   assign chk_run = (chk_q == lspc_pkg::CHK_RUN);

   always_comb begin
      ol_cfg_d    = ol_cfg_q;
      ol_per_d    = ol_per_q;
      phase_cfg_d = phase_cfg_q;
      sp_d        = sp_q;
      chk_d       = chk_q;
      chk_pass_d  = chk_pass_q;
      if (chk_run && &hit) begin
         chk_d      = lspc_pkg::CHK_IDLE;
         chk_pass_d = 1'b1;
      end
      if (CMD_WR_IN) begin
         if (CMD_CODE_IN == `LSPC_CMD_OPEN_LOOP) begin
            ol_cfg_d = CMD_WDATA_IN;
         end else if (CMD_CODE_IN == `LSPC_CMD_PHASE) begin
            phase_cfg_d = CMD_WDATA_IN[4:0];
         end else if (CMD_CODE_IN == `LSPC_CMD_SP_CODE) begin
            sp_d[CMD_PAGE_IN].code = CMD_WDATA_IN[4:0];
         end else if (CMD_CODE_IN == `LSPC_CMD_SP_TRIM) begin
            sp_d[CMD_PAGE_IN].trim = CMD_WDATA_IN[5:0];
         end else if (CMD_CODE_IN == `LSPC_CMD_SP_OFFSET) begin
            sp_d[CMD_PAGE_IN].offs = CMD_WDATA_IN[5:0];
         end else if (CMD_CODE_IN == `LSPC_CMD_MARGIN_UP) begin
            sp_d[CMD_PAGE_IN].up = CMD_WDATA_IN[5:0];
         end else if (CMD_CODE_IN == `LSPC_CMD_MARGIN_DOWN) begin
            sp_d[CMD_PAGE_IN].down = CMD_WDATA_IN[5:0];
         end else if (CMD_CODE_IN == `LSPC_CMD_CEILING) begin
            sp_d[CMD_PAGE_IN].ceil = CMD_WDATA_IN[5:0];
         end else if (CMD_CODE_IN == `LSPC_CMD_MARGIN_MODE) begin
            sp_d[CMD_PAGE_IN].margin = lspc_pkg::lspc_margin_t'(CMD_WDATA_IN[1:0]);
         end else if (CMD_CODE_IN == `LSPC_CMD_OL_PERIOD) begin
            ol_per_d = CMD_WDATA_IN;
         end else if (CMD_CODE_IN == `LSPC_CMD_CONTROL) begin
            if (CMD_WDATA_IN[`LSPC_CTRL_CHK_BIT] && !chk_run) begin
               chk_d      = lspc_pkg::CHK_RUN;
               chk_pass_d = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         ol_cfg_q    <= `LSPC_OL_CFG_RST;
         ol_per_q    <= `LSPC_OL_PER_RST;
         phase_cfg_q <= `LSPC_PHASE_RST;
         sp_q[0]     <= sp_rst;
         sp_q[1]     <= sp_rst;
         chk_q       <= lspc_pkg::CHK_IDLE;
         chk_pass_q  <= 1'b0;
      end else begin
         ol_cfg_q    <= ol_cfg_d;
         ol_per_q    <= ol_per_d;
         phase_cfg_q <= phase_cfg_d;
         sp_q        <= sp_d;
         chk_q       <= chk_d;
         chk_pass_q  <= chk_pass_d;
      end
   end

   // ===================================================================
   // feedback-open monitor: blanking per loop
   logic [1:0]       en_prev_q, rise, armed;
   logic [1:0][14:0] blank_q, blank_d;

   assign rise     = LOOP_ENABLE_IN & ~en_prev_q;
   assign comp     = {SENSE_RTN_CMP_IN[1], SENSE_POS_CMP_IN[1],
                      SENSE_RTN_CMP_IN[0], SENSE_POS_CMP_IN[0]};
   assign comp_eff = comp | {4{chk_run}};

   always_comb begin
      for (int l = 0; l < 2; l++) begin
         armed[l] = (blank_q[l] >= 15'(BLANK_CYC));
         if (rise[l]) begin
            blank_d[l] = 15'h0000;
         end else if (armed[l]) begin
            blank_d[l] = blank_q[l];
         end else begin
            blank_d[l] = blank_q[l] + 15'h0001;
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         en_prev_q <= LOOP_ENABLE_IN;
         blank_q   <= '0;
      end else begin
         en_prev_q <= LOOP_ENABLE_IN;
         blank_q   <= blank_d;
      end
   end

   // ===================================================================
   // feedback-open monitor: filter and latch per comparator
   genvar gm;
   for (gm = 0; gm < 4; gm++) begin : g_mon
      logic [11:0] filt_q, filt_d;
      logic        flag_q, flag_d, edge_q, edge_d, live, hit_m;
      always_comb begin
         live   = comp_eff[gm] && (armed[gm/2] || chk_run);
         hit_m  = live && (filt_q == 12'(`LSPC_FILT_CYC - 1));
         filt_d = !live ? 12'h000 : (hit_m ? filt_q : filt_q + 12'h001);
         edge_d = flag_q && (edge_q || rise[gm/2]);
         flag_d = flag_q;
         if (hit_m && !chk_run) begin
            flag_d = 1'b1;
         end else if (flag_q && edge_q && !comp[gm]) begin
            flag_d = 1'b0;
         end
      end
      always_ff @(posedge REF_CLK_IN) begin
         if (SYS_RST_IN) begin
            filt_q <= 12'h000;
            flag_q <= 1'b0;
            edge_q <= 1'b0;
         end else begin
            filt_q <= filt_d;
            flag_q <= flag_d;
            edge_q <= edge_d;
         end
      end
      assign hit[gm]  = hit_m;
      assign flag[gm] = flag_q;
   end

   // ===================================================================
   // open-loop timing and phase outputs
   logic [15:0] per_q, per_d, per_last, on_cyc;
   logic [3:0]  ol_n;
   logic        ol_en, safe;
   logic [15:0] phase_mask;
   logic [7:0]  pwm_d, oe_d, phase_current_sense_d;
   logic [15:0] rdata_d;
   logic [1:0][10:0] ref_d;

   assign ol_en      = ol_cfg_q[`LSPC_OL_EN_BIT];
   assign safe       = |flag;
   assign phase_mask = lspc_phase_mask(phase_cfg_q);

   always_comb begin
      on_cyc = 16'((32'(ol_cfg_q[`LSPC_OL_ON_MSB:`LSPC_OL_ON_LSB]) * `LSPC_OL_COARSE_NS)
               / (`LSPC_OL_FINE_DIV * `LSPC_CLK_NS));
      if (on_cyc == 16'h0000) begin
         on_cyc = 16'h0001;
      end
      ol_n = ol_cfg_q[`LSPC_OL_NPH_MSB:`LSPC_OL_NPH_LSB];
      if (ol_n > `LSPC_MAX_PHASES) begin
         ol_n = `LSPC_MAX_PHASES;
      end
      per_last = (ol_per_q <= 16'h0001) ? 16'h0000 : ol_per_q - 16'h0001;
      per_d    = (!ol_en || per_q >= per_last) ? 16'h0000 : per_q + 16'h0001;
      for (int i = 0; i < 8; i++) begin
         phase_current_sense_d[i] = phase_mask[i] | phase_mask[i + 8];
         if (safe) begin
            pwm_d[i] = 1'b0;
            oe_d[i]  = 1'b0;
         end else if (ol_en) begin
            oe_d[i]  = (4'(i) < ol_n);
            pwm_d[i] = (4'(i) < ol_n) && (per_q < on_cyc);
         end else begin
            oe_d[i]  = phase_current_sense_d[i];
            pwm_d[i] = phase_current_sense_d[i] & PWM_LOOP_IN[i];
         end
      end
      for (int l = 0; l < 2; l++) begin
         ref_d[l] = lspc_ref(sp_q[l]);
      end
   end

   // ===================================================================
   // command readback
   always_comb begin
      rdata_d = 16'h0000;
      if (CMD_CODE_IN == `LSPC_CMD_OPEN_LOOP) begin
         rdata_d = ol_cfg_q;
      end else if (CMD_CODE_IN == `LSPC_CMD_PHASE) begin
         rdata_d = {11'h000, phase_cfg_q};
      end else if (CMD_CODE_IN == `LSPC_CMD_SP_CODE) begin
         rdata_d = {11'h000, sp_q[CMD_PAGE_IN].code};
      end else if (CMD_CODE_IN == `LSPC_CMD_SP_TRIM) begin
         rdata_d = {10'h000, sp_q[CMD_PAGE_IN].trim};
      end else if (CMD_CODE_IN == `LSPC_CMD_SP_OFFSET) begin
         rdata_d = {10'h000, sp_q[CMD_PAGE_IN].offs};
      end else if (CMD_CODE_IN == `LSPC_CMD_MARGIN_UP) begin
         rdata_d = {10'h000, sp_q[CMD_PAGE_IN].up};
      end else if (CMD_CODE_IN == `LSPC_CMD_MARGIN_DOWN) begin
         rdata_d = {10'h000, sp_q[CMD_PAGE_IN].down};
      end else if (CMD_CODE_IN == `LSPC_CMD_CEILING) begin
         rdata_d = {10'h000, sp_q[CMD_PAGE_IN].ceil};
      end else if (CMD_CODE_IN == `LSPC_CMD_MARGIN_MODE) begin
         rdata_d = {14'h0000, sp_q[CMD_PAGE_IN].margin};
      end else if (CMD_CODE_IN == `LSPC_CMD_OL_PERIOD) begin
         rdata_d = ol_per_q;
      end else if (CMD_CODE_IN == `LSPC_CMD_STATUS) begin
         rdata_d[3:0]               = flag;
         rdata_d[`LSPC_ST_CHK_BUSY] = chk_run;
         rdata_d[`LSPC_ST_CHK_PASS] = chk_pass_q;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         per_q             <= 16'h0000;
         PWM_OUT           <= 8'h00;
         PWM_OE_OUT        <= 8'h00;
         PHASE_CURRENT_SENSE_EN_OUT       <= 8'h00;
         SENSE_OPEN_OUT    <= 2'h0;
         RETURN_OPEN_OUT   <= 2'h0;
         SAFE_TRISTATE_OUT <= 1'b0;
         REF_CODE_OUT      <= '0;
         CMD_RDATA_OUT     <= 16'h0000;
      end else begin
         per_q             <= per_d;
         PWM_OUT           <= pwm_d;
         PWM_OE_OUT        <= oe_d;
         PHASE_CURRENT_SENSE_EN_OUT       <= phase_current_sense_d;
         SENSE_OPEN_OUT    <= {flag[2], flag[0]};
         RETURN_OPEN_OUT   <= {flag[3], flag[1]};
         SAFE_TRISTATE_OUT <= safe;
         REF_CODE_OUT      <= ref_d;
         CMD_RDATA_OUT     <= rdata_d;
      end
   end

   // ===================================================================
   // assertions
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   sequence s_pos_held;
      armed[0] && comp[0] && !chk_run && g_mon[0].filt_q == 12'(`LSPC_FILT_CYC - 1);
   endsequence
   sequence s_rtn_held;
      armed[1] && comp[3] && !chk_run && g_mon[3].filt_q == 12'(`LSPC_FILT_CYC - 1);
   endsequence

   property p_sense_open_set;
      s_pos_held |=> flag[0] ##1 SENSE_OPEN_OUT[0];
   endproperty
   a_sense_open_set: assert property (p_sense_open_set) else $error("sense open not set");

   property p_return_open_set;
      s_rtn_held |=> flag[3] ##1 RETURN_OPEN_OUT[1];
   endproperty
   a_return_open_set: assert property (p_return_open_set) else $error("return open not set");

   property p_blank_gate;
      $rose(flag[0]) |-> $past(armed[0]);
   endproperty
   a_blank_gate: assert property (p_blank_gate) else $error("flag set during blanking");

   property p_flag_hold;
      flag[0] && (comp[0] || !g_mon[0].edge_q) |=> flag[0];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag cleared early");

   property p_safe_tristate_state;
      safe |=> (PWM_OE_OUT == 8'h00) && SAFE_TRISTATE_OUT;
   endproperty
   a_safe_tristate_state: assert property (p_safe_tristate_state) else $error("pwm driven in safe state");

   property p_selfcheck;
      chk_run && (&hit) |=> chk_pass_q && !chk_run && $stable(flag);
   endproperty
   a_selfcheck: assert property (p_selfcheck) else $error("self-check did not pass");

   property p_unassigned;
      !ol_en && !safe |=> ((PWM_OE_OUT & ~$past(phase_current_sense_d)) == 8'h00)
                          && PHASE_CURRENT_SENSE_EN_OUT == $past(phase_current_sense_d);
   endproperty
   a_unassigned: assert property (p_unassigned) else $error("unassigned phase driven");

   property p_split_limit;
      $countones(phase_mask[15:8]) <= 4 && (phase_mask[15:8] & phase_mask[7:0]) == 8'h00;
   endproperty
   a_split_limit: assert property (p_split_limit) else $error("phase split illegal");

   property p_reserved;
      phase_cfg_q == 5'h1f |-> phase_mask == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code drives phases");

   property p_ceiling;
      lspc_sum(sp_q[0]) >= $signed({2'h0, sp_q[0].ceil}) |=>
         REF_CODE_OUT[0] == 11'(((12'($past(sp_q[0].ceil)) + 12'h001) << 5) - 12'h001);
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("ceiling clamp wrong");

   property p_code_zero;
      sp_q[0].code == 5'h00 && lspc_sum(sp_q[0]) < $signed({2'h0, sp_q[0].ceil})
         |=> REF_CODE_OUT[0] == 11'h000;
   endproperty
   a_code_zero: assert property (p_code_zero) else $error("code zero not 0 V");

   property p_open_loop;
      ol_en && !safe && ol_n != 4'h0 && per_q == 16'h0000 |=> PWM_OUT[0] && PWM_OE_OUT[0];
   endproperty
   a_open_loop: assert property (p_open_loop) else $error("open-loop pulse missing");

endmodule

// *** lspc_stage_model.sv ***
// power stage and feedback network model facing the phase and sense pins
`timescale 1ns/1ps
module lspc_stage_model (
   input  wire logic       clk_in,
   input  wire logic [1:0] open_pos_in,
   input  wire logic [1:0] open_rtn_in,
   output logic      [1:0] pos_cmp_out,
   output logic      [1:0] rtn_cmp_out,
   output logic      [7:0] pwm_loop_out
);
   // ======================================================================
   // sense lines
   // broken feedback lets the weak pull-up lift the pin over threshold
   assign pos_cmp_out = open_pos_in;
   assign rtn_cmp_out = open_rtn_in;
   // ======================================================================
   // closed-loop pulses
   // rotating pattern, so a stale phase value never looks right
   logic [7:0] pat_q = 8'h13;
   always @(posedge clk_in) begin
      pat_q <= #2 {pat_q[6:0], pat_q[7]};
   end
   assign pwm_loop_out = pat_q;
endmodule

// *** lspc_bench.sv ***
// self-checking bench of the loop setpoint and phase configuration block
`timescale 1ns/1ps
`include "lspc_defs.svh"
module lspc_bench;
   // ======================================================================
   // signals
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             wr = 1'b0;
   logic [3:0]       code = 4'h0;
   logic             page = 1'b0;
   logic [15:0]      wdata = 16'h0000;
   logic [1:0]       open_pos = 2'h0;
   logic [1:0]       open_rtn = 2'h0;
   logic [1:0]       loop_en = 2'h3;
   logic             look = 1'b0;
   logic [2:0]       look_id = 3'h0;
   logic [31:0]      rnd = 32'ha511;
   logic [7:0]       loop_seen = 8'h00;
   logic [7:0]       cur_mask = 8'h00;
   logic [15:0]      rdata;
   logic [1:0]       pos_cmp;
   logic [1:0]       rtn_cmp;
   logic [7:0]       pwm_loop;
   logic [7:0]       pwm;
   logic [7:0]       pwm_oe;
   logic [7:0]       phase_current_sense_en;
   logic [1:0]       sense_open;
   logic [1:0]       rtn_open;
   logic             safe;
   logic [1:0][10:0] ref_code;
   logic [15:0]      exp_q[$];
   int               n_fail = 0;
   int               total_checks = 0;
   int               n;
   always #20 clk = ~clk;
   lspc_top #(.BLANK_CYC(20)) i_dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .CMD_WR_IN(wr),
      .CMD_CODE_IN(code), .CMD_PAGE_IN(page), .CMD_WDATA_IN(wdata), .CMD_RDATA_OUT(rdata),
      .SENSE_POS_CMP_IN(pos_cmp), .SENSE_RTN_CMP_IN(rtn_cmp), .LOOP_ENABLE_IN(loop_en),
      .PWM_LOOP_IN(pwm_loop), .PWM_OUT(pwm), .PWM_OE_OUT(pwm_oe), .PHASE_CURRENT_SENSE_EN_OUT(phase_current_sense_en),
      .SENSE_OPEN_OUT(sense_open), .RETURN_OPEN_OUT(rtn_open), .SAFE_TRISTATE_OUT(safe),
      .REF_CODE_OUT(ref_code));
   lspc_stage_model i_stage (.clk_in(clk), .open_pos_in(open_pos), .open_rtn_in(open_rtn),
      .pos_cmp_out(pos_cmp), .rtn_cmp_out(rtn_cmp), .pwm_loop_out(pwm_loop));
   // ======================================================================
   // comparison and monitor
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask
   function automatic logic [15:0] obs(input logic [2:0] id);
      case (id)
         3'h0: obs = {5'h00, ref_code[0]};
         3'h1: obs = {5'h00, ref_code[1]};
         3'h2: obs = {8'h00, pwm_oe};
         3'h3: obs = {8'h00, phase_current_sense_en};
         3'h4: obs = rdata;
         3'h6: obs = {8'h00, pwm ^ (cur_mask & loop_seen)};
         default: obs = {11'h000, safe, rtn_open, sense_open};
      endcase
   endfunction
   always @(posedge clk) begin
      loop_seen <= pwm_loop;
      if (look) begin
         cmp($sformatf("output %0d", look_id), exp_q.pop_front(), obs(look_id));
      end
   end
   // ======================================================================
   // drivers and expectations
   task automatic tick;
      @(posedge clk) #2;
   endtask
   task automatic chk(input logic [2:0] id, input logic [15:0] e);
      tick;
      exp_q.push_back(e);
      look_id = id;
      look = 1'b1;
      tick;
      look = 1'b0;
   endtask
   task automatic wr_cmd(input logic [3:0] c, input logic p, input logic [15:0] d);
      tick;
      wr = 1'b1;
      code = c;
      page = p;
      wdata = d;
      tick;
      wr = 1'b0;
   endtask
   task automatic rd(input logic [3:0] c, input logic [15:0] e);
      tick;
      code = c;
      page = 1'b0;
      chk(3'h4, e);
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [15:0] ref_exp(input logic [4:0] c, input logic [5:0] t,
         input logic [5:0] o, input logic [5:0] cl, input logic [1:0] md, input logic [5:0] m);
      int s;
      int b;
      s = int'(c) + int'($signed(t)) + int'($signed(o));
      b = (int'(c) + 9) * 41;
      if (s >= int'(cl)) b = 32 * (int'(cl) + 1) - 1;
      else if (c == 5'h00) b = 0;
      else if (md == 2'b01 || md == 2'b10) b = b + int'(m);
      else b = b + int'($signed(t)) + int'($signed(o));
      if (b > 2047) b = 2047;
      if (b < 0) b = 0;
      return b[15:0];
   endfunction
   task automatic sp(input logic p, input logic [4:0] c, input logic [5:0] t,
         input logic [5:0] o, input logic [5:0] cl, input logic [1:0] md, input logic [5:0] m);
      wr_cmd(`LSPC_CMD_SP_CODE, p, {11'h000, c});
      wr_cmd(`LSPC_CMD_SP_TRIM, p, {10'h000, t});
      wr_cmd(`LSPC_CMD_SP_OFFSET, p, {10'h000, o});
      wr_cmd(`LSPC_CMD_CEILING, p, {10'h000, cl});
      wr_cmd(`LSPC_CMD_MARGIN_UP, p, {10'h000, m});
      wr_cmd(`LSPC_CMD_MARGIN_DOWN, p, {10'h000, m});
      wr_cmd(`LSPC_CMD_MARGIN_MODE, p, {14'h0000, md});
      chk({2'b00, p}, ref_exp(c, t, o, cl, md, m));
   endtask
   function automatic logic [7:0] ph_mask(input int c);
      int n1;
      int n2;
      if (c == 0 || c == 31) return 8'h00;
      n2 = (c <= 8) ? 0 : (c <= 15) ? 1 : (c <= 21) ? 2 : (c <= 26) ? 3 : 4;
      n1 = c - ((n2 == 0) ? 0 : (n2 == 1) ? 8 : (n2 == 2) ? 15 : (n2 == 3) ? 21 : 26);
      return 8'((1 << n1) - 1) | 8'(((1 << n2) - 1) << (8 - n2));
   endfunction
   task automatic wait_safe(output int k);
      k = 0;
      while (safe !== 1'b1 && k < 4000) begin
         tick;
         k++;
      end
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ======================================================================
   // watchdog and main sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report;
   end
   initial begin
      repeat (16) tick;
      rst = 1'b0;
      chk(3'h0, 16'h001f);
      rd(`LSPC_CMD_SP_CODE, 16'h0006);
      for (int c = 3; c <= 7; c++) rd(4'(c), 16'h0000);
      rd(4'hc, 16'h0000);
      loop_en = 2'h0;
      sp(1'b0, 5'h0a, 6'h03, 6'h3f, 6'h3f, 2'b00, 6'h00);
      sp(1'b1, 5'h00, 6'h00, 6'h00, 6'h3f, 2'b00, 6'h00);
      sp(1'b0, 5'h1f, 6'h00, 6'h00, 6'h3f, 2'b00, 6'h00);
      sp(1'b0, 5'h0a, 6'h00, 6'h00, 6'h05, 2'b00, 6'h00);
      sp(1'b1, 5'h0a, 6'h00, 6'h00, 6'h0a, 2'b00, 6'h00);
      sp(1'b0, 5'h0a, 6'h00, 6'h00, 6'h0b, 2'b00, 6'h00);
      sp(1'b0, 5'h08, 6'h05, 6'h00, 6'h3f, 2'b01, 6'h11);
      sp(1'b1, 5'h08, 6'h00, 6'h00, 6'h3f, 2'b10, 6'h2a);
      repeat (8) begin
         rnd = lfsr(rnd);
         sp(rnd[0], rnd[5:1] | 5'h01, rnd[11:6], rnd[17:12], rnd[23:18], rnd[25:24],
            rnd[31:26]);
      end
      loop_en = 2'h3;
      for (int c = 0; c < 32; c++) begin
         cur_mask = ph_mask(c);
         wr_cmd(`LSPC_CMD_PHASE, 1'b0, 16'(c));
         chk(3'h6, 16'h0000);
         chk(3'h2, {8'h00, ph_mask(c)});
         chk(3'h3, {8'h00, ph_mask(c)});
      end
      wr_cmd(`LSPC_CMD_OL_PERIOD, 1'b0, 16'h0028);
      wr_cmd(`LSPC_CMD_OPEN_LOOP, 1'b0, 16'hf7e7);
      chk(3'h2, 16'h0007);
      n = 0;
      repeat (40) begin
         tick;
         n += int'(pwm[0]);
      end
      cmp("on cycles", 16'(((30 * 64 + 63) * 25) / 2560), 16'(n));
      wr_cmd(`LSPC_CMD_OPEN_LOOP, 1'b0, 16'h0000);
      wr_cmd(`LSPC_CMD_CONTROL, 1'b0, 16'h0001);
      rd(`LSPC_CMD_STATUS, 16'h0010);
      repeat (2300) tick;
      rd(`LSPC_CMD_STATUS, 16'h0020);
      open_pos[0] = 1'b1;
      wait_safe(n);
      cmp("sense filter", 16'h0001, 16'(n >= 2200 && n <= 3300));
      chk(3'h5, 16'h0011);
      chk(3'h2, 16'h0000);
      open_pos[0] = 1'b0;
      chk(3'h5, 16'h0011);
      loop_en[0] = 1'b0;
      tick;
      loop_en[0] = 1'b1;
      repeat (4) tick;
      chk(3'h5, 16'h0000);
      loop_en[1] = 1'b0;
      tick;
      loop_en[1] = 1'b1;
      open_rtn[1] = 1'b1;
      wait_safe(n);
      cmp("blanked filter", 16'h0001, 16'(n >= 2220 && n <= 3400));
      chk(3'h5, 16'h0018);
      rd(`LSPC_CMD_STATUS, 16'h0028);
      final_report;
   end
endmodule
